// file: design/tsc_regs.sv
module tsc_regs #(
  parameter int unsigned UNIT_CYC = tsc_pkg::PERIOD_UNIT_CYC,
  parameter logic [7:0]  DEV_ID   = 8'h5A, // arbitrary value
  parameter logic [6:0]  I2C_ADDR = 7'h57
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic mod_clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output logic      sda_o,
  output logic      sda_oe_n_o,
  input  wire logic chip_disable_pin_i,
  input  wire logic trigger_i,
  input  wire logic vdd_ok_i,
  output logic      emitter_drive_o,
  output logic      sample_start_o,
  output logic      cal_sample_o
);
  // pin synchronisers: scl, sda, disable, trigger, power-good
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  logic [4:0] prev_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= 5'h03;
      sync2_q <= 5'h03;
      prev_q  <= 5'h03;
    end else begin
      sync1_q <= {vdd_ok_i, trigger_i, chip_disable_pin_i, sda_i, scl_i};
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  logic scl_s, sda_s, cen_s, vdd_s;
  logic scl_rise, scl_fall, start_w, stop_w, trig_edge;
  assign scl_s     = sync2_q[0];
  assign sda_s     = sync2_q[1];
  assign cen_s     = sync2_q[2];
  assign vdd_s     = sync2_q[4];
  assign scl_rise  = scl_s & ~prev_q[0];
  assign scl_fall  = ~scl_s & prev_q[0];
  assign start_w   = scl_s & prev_q[0] & prev_q[1] & ~sda_s;
  assign stop_w    = scl_s & prev_q[0] & ~prev_q[1] & sda_s;
  assign trig_edge = sync2_q[3] & ~prev_q[3];

  // register file
  logic       mc_q;
  logic [3:0] integ_q;
  logic [7:0] period_q;
  logic [1:0] scale_q;
  logic [7:0] acq_q;
  logic       ready_q;
  logic       enabled_w;
  logic [7:0] status_w;
  tsc_pkg::tsc_wr_s wr_q;

  assign enabled_w = ~mc_q & ~cen_s;
  assign status_w  = {5'h00, vdd_s, ready_q, enabled_w};

  function automatic logic [7:0] rd_reg(input logic [7:0] a);
    case (a)
      tsc_pkg::ADDR_DEV_ID:   rd_reg = DEV_ID;
      tsc_pkg::ADDR_MSTR_CTL: rd_reg = {7'h00, mc_q};
      tsc_pkg::ADDR_STATUS:   rd_reg = status_w;
      tsc_pkg::ADDR_INTEG:    rd_reg = {4'h0, integ_q};
      tsc_pkg::ADDR_PERIOD:   rd_reg = period_q;
      tsc_pkg::ADDR_SCALE:    rd_reg = {6'h00, scale_q};
      tsc_pkg::ADDR_ACQ_CTL:  rd_reg = acq_q;
      default:                rd_reg = 8'h00;
    endcase
  endfunction

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mc_q     <= tsc_pkg::RST_MSTR_CTL;
      integ_q  <= tsc_pkg::RST_INTEG;
      period_q <= tsc_pkg::RST_PERIOD;
      scale_q  <= tsc_pkg::RST_SCALE;
      acq_q    <= tsc_pkg::RST_ACQ_CTL;
    end else if (wr_q.vld) begin
      case (wr_q.addr)
        tsc_pkg::ADDR_MSTR_CTL: mc_q     <= wr_q.data[0];
        tsc_pkg::ADDR_INTEG:    integ_q  <= wr_q.data[3:0];
        tsc_pkg::ADDR_PERIOD:   period_q <= wr_q.data;
        tsc_pkg::ADDR_SCALE:    scale_q  <= wr_q.data[1:0];
        tsc_pkg::ADDR_ACQ_CTL:  acq_q    <= wr_q.data;
        default:                ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) ready_q <= 1'b0;
    else          ready_q <= 1'b1;
  end

  // i2c slave
  tsc_pkg::tsc_i2c_e i2c_q;
  logic [3:0] bit_q;
  logic [7:0] shift_q;
  logic [7:0] tx_q;
  logic [7:0] ptr_q;
  logic       ack_q;
  logic       rw_q;
  logic       mack_q;
  logic       sda_low_q;
  logic       ack_end_w;
  logic [7:0] ptr_inc_w;
  logic [7:0] rd_now_w;
  logic [7:0] rd_next_w;

  assign ack_end_w = scl_fall & ack_q & ~start_w & ~stop_w;
  assign ptr_inc_w = ptr_q + 8'h01;
  assign rd_now_w  = rd_reg(ptr_q);
  assign rd_next_w = rd_reg(ptr_inc_w);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      i2c_q     <= tsc_pkg::TSC_I_IDLE;
      bit_q     <= 4'h0;
      shift_q   <= 8'h00;
      tx_q      <= 8'h00;
      ptr_q     <= 8'h00;
      ack_q     <= 1'b0;
      rw_q      <= 1'b0;
      mack_q    <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (start_w) begin
      i2c_q     <= tsc_pkg::TSC_I_DEVID;
      bit_q     <= 4'h0;
      ack_q     <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (stop_w) begin
      // a stop before the data acknowledge ends leaves wr_q idle
      i2c_q     <= tsc_pkg::TSC_I_IDLE;
      bit_q     <= 4'h0;
      ack_q     <= 1'b0;
      sda_low_q <= 1'b0;
    end else if (i2c_q != tsc_pkg::TSC_I_IDLE) begin
      if (scl_rise) begin
        if (ack_q) begin
          mack_q <= ~sda_s;
        end else if (bit_q < 4'h8) begin
          shift_q <= {shift_q[6:0], sda_s};
          bit_q   <= bit_q + 4'h1;
        end
      end else if (scl_fall) begin
        if (ack_q) begin
          ack_q     <= 1'b0;
          bit_q     <= 4'h0;
          sda_low_q <= 1'b0;
          case (i2c_q)
            tsc_pkg::TSC_I_DEVID: begin
              if (rw_q) begin
                i2c_q     <= tsc_pkg::TSC_I_RDATA;
                tx_q      <= {rd_now_w[6:0], 1'b0};
                sda_low_q <= ~rd_now_w[7];
              end else begin
                i2c_q <= tsc_pkg::TSC_I_REGAD;
              end
            end
            tsc_pkg::TSC_I_REGAD: i2c_q <= tsc_pkg::TSC_I_WDATA;
            tsc_pkg::TSC_I_WDATA: ptr_q <= ptr_inc_w;
            tsc_pkg::TSC_I_RDATA: begin
              if (mack_q) begin
                ptr_q     <= ptr_inc_w;
                tx_q      <= {rd_next_w[6:0], 1'b0};
                sda_low_q <= ~rd_next_w[7];
              end else begin
                i2c_q <= tsc_pkg::TSC_I_IDLE;
              end
            end
            default: i2c_q <= tsc_pkg::TSC_I_IDLE;
          endcase
        end else if (bit_q == 4'h8) begin
          case (i2c_q)
            tsc_pkg::TSC_I_DEVID: begin
              if (shift_q[7:1] == I2C_ADDR) begin
                ack_q     <= 1'b1;
                sda_low_q <= 1'b1;
                rw_q      <= shift_q[0];
              end else begin
                i2c_q <= tsc_pkg::TSC_I_IDLE;
              end
            end
            tsc_pkg::TSC_I_REGAD: begin
              ptr_q     <= shift_q;
              ack_q     <= 1'b1;
              sda_low_q <= 1'b1;
            end
            tsc_pkg::TSC_I_WDATA: begin
              ack_q     <= 1'b1;
              sda_low_q <= 1'b1;
            end
            tsc_pkg::TSC_I_RDATA: begin
              ack_q     <= 1'b1; // release for the master's answer
              sda_low_q <= 1'b0;
            end
            default: i2c_q <= tsc_pkg::TSC_I_IDLE;
          endcase
        end else if (i2c_q == tsc_pkg::TSC_I_RDATA) begin
          sda_low_q <= ~tx_q[7];
          tx_q      <= {tx_q[6:0], 1'b0};
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
    end else begin
      wr_q.vld  <= ack_end_w & (i2c_q == tsc_pkg::TSC_I_WDATA);
      wr_q.addr <= ptr_q;
      wr_q.data <= shift_q;
    end
  end

  assign sda_o      = 1'b0;
  assign sda_oe_n_o = ~sda_low_q;

  // acquisition scheduler
  tsc_pkg::tsc_sched_e sched_q, sched_d;
  logic [15:0] pre_q;
  logic [11:0] unit_q;
  logic [7:0]  light_q, light_d;
  logic [11:0] units_w;
  logic [7:0]  thr_w;
  logic        elapsed_w, start_s, cal_s;

  // both factors are read live, so a rewrite takes effect at once
  assign units_w = 12'(({4'h0, period_q} + 12'h001) << scale_q);
  assign thr_w   = 8'(tsc_pkg::CAL_BASE_CNT
                      << acq_q[tsc_pkg::CAL_RATE_LSB +: 2]);
  // at or past the end, so shortening the interval cannot strand the count
  assign elapsed_w = (pre_q == 16'(UNIT_CYC - 1)) &&
                     (unit_q >= units_w - 12'h001);

  always_comb begin
    sched_d = sched_q;
    light_d = light_q;
    start_s = 1'b0;
    cal_s   = 1'b0;
    case (sched_q)
      tsc_pkg::TSC_S_IDLE: begin
        if (trig_edge && enabled_w) begin
          start_s = 1'b1;
          if (!acq_q[tsc_pkg::ACQ_MODE_BIT]) begin
            sched_d = tsc_pkg::TSC_S_RUN;
            light_d = 8'h01;
          end else if (acq_q[tsc_pkg::LIGHT_EN_BIT]) begin
            cal_s   = ~acq_q[tsc_pkg::CAL_ORDER_BIT];
            sched_d = tsc_pkg::TSC_S_SHOT;
          end
        end
      end
      tsc_pkg::TSC_S_RUN: begin
        if (acq_q[tsc_pkg::ACQ_MODE_BIT]) begin
          sched_d = tsc_pkg::TSC_S_IDLE;
        end else if (elapsed_w) begin
          start_s = 1'b1;
          if (acq_q[tsc_pkg::LIGHT_EN_BIT] && light_q == thr_w) begin
            cal_s   = 1'b1;
            light_d = 8'h00;
          end else begin
            light_d = acq_q[tsc_pkg::LIGHT_EN_BIT] ? light_q + 8'h01 : 8'h00;
          end
        end
      end
      tsc_pkg::TSC_S_SHOT: begin
        if (elapsed_w) begin
          start_s = 1'b1;
          cal_s   = acq_q[tsc_pkg::CAL_ORDER_BIT];
          sched_d = tsc_pkg::TSC_S_IDLE;
        end
      end
      default: sched_d = tsc_pkg::TSC_S_IDLE;
    endcase
    if (!enabled_w) begin
      sched_d = tsc_pkg::TSC_S_IDLE;
      start_s = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sched_q <= tsc_pkg::TSC_S_IDLE;
      light_q <= 8'h00;
      pre_q   <= 16'h0000;
      unit_q  <= 12'h000;
    end else begin
      sched_q <= sched_d;
      light_q <= light_d;
      if (start_s || sched_q == tsc_pkg::TSC_S_IDLE) begin
        pre_q  <= 16'h0000;
        unit_q <= 12'h000;
      end else if (pre_q == 16'(UNIT_CYC - 1)) begin
        pre_q  <= 16'h0000;
        unit_q <= unit_q + 12'h001;
      end else begin
        pre_q <= pre_q + 16'h0001;
      end
    end
  end

  // sample request to the modulation domain: toggle plus held fields
  tsc_pkg::tsc_xfer_s xfer_q;
  logic req_tgl_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      xfer_q         <= '0;
      req_tgl_q      <= 1'b0;
      sample_start_o <= 1'b0;
      cal_sample_o   <= 1'b0;
    end else begin
      sample_start_o <= start_s;
      if (start_s) begin
        xfer_q.cal   <= cal_s;
        xfer_q.exp   <= (integ_q > tsc_pkg::INTEG_MAX_EXP) ?
                        tsc_pkg::INTEG_MAX_EXP : integ_q;
        req_tgl_q    <= ~req_tgl_q;
        cal_sample_o <= cal_s;
      end
    end
  end

  // modulation domain; fields are loaded with each toggle and held until the next start
  logic [2:0]  mtgl_q;
  logic [19:0] burst_q;
  logic        emit_q, emit_n_q;
  always_ff @(posedge mod_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mtgl_q  <= 3'h0;
      burst_q <= 20'h00000;
      emit_q  <= 1'b0;
    end else begin
      mtgl_q <= {mtgl_q[1:0], req_tgl_q};
      if (mtgl_q[2] ^ mtgl_q[1]) begin
        // calibration samples run without light
        burst_q <= xfer_q.cal ? 20'h00000 :
                   20'(tsc_pkg::INTEG_PULSES) << xfer_q.exp;
      end else if (burst_q != 20'h00000) begin
        burst_q <= burst_q - 20'h00001;
      end
      emit_q <= (burst_q != 20'h00000);
    end
  end

  // enable retimed on the falling edge so the gated clock cannot glitch
  always_ff @(negedge mod_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) emit_n_q <= 1'b0;
    else          emit_n_q <= emit_q;
  end
  assign emitter_drive_o = emit_n_q & mod_clk_i;

  // helper: cycles since last start, and a rewrite seen in between
  int unsigned since_q;
  logic        chg_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      since_q <= 0;
      chg_q   <= 1'b0;
    end else begin
      since_q <= start_s ? 0 : since_q + 1;
      chg_q   <= start_s ? 1'b0 : chg_q | wr_q.vld;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  disable_stops_a: assert property (
    !enabled_w |=> sched_q == tsc_pkg::TSC_S_IDLE && !sample_start_o)
    else $error("sampling while disabled");
  status_map_a: assert property (
    rd_reg(tsc_pkg::ADDR_STATUS) == {5'h00, vdd_s, ready_q, ~mc_q & ~cen_s})
    else $error("status read wrong");
  period_len_a: assert property (
    start_s && sched_q == tsc_pkg::TSC_S_RUN && !chg_q && !wr_q.vld
    |-> since_q == UNIT_CYC * units_w - 1)
    else $error("sample spacing wrong");
  idle_quiet_a: assert property (
    sched_q == tsc_pkg::TSC_S_IDLE && !trig_edge |-> !start_s)
    else $error("start without trigger");
  shot_order_a: assert property (
    start_s && sched_q == tsc_pkg::TSC_S_SHOT
    |-> cal_s == acq_q[tsc_pkg::CAL_ORDER_BIT])
    else $error("single shot order wrong");
  cal_rate_a: assert property (
    start_s && cal_s && sched_q == tsc_pkg::TSC_S_RUN |-> light_q == thr_w)
    else $error("calibration rate wrong");
  free_run_a: assert property (
    sched_q == tsc_pkg::TSC_S_RUN && elapsed_w && enabled_w &&
    !acq_q[tsc_pkg::ACQ_MODE_BIT] |=> sample_start_o)
    else $error("free run missed sample");
  read_incr_a: assert property (
    ack_end_w && i2c_q == tsc_pkg::TSC_I_RDATA && mack_q
    |=> ptr_q == $past(ptr_q) + 8'h01)
    else $error("read address not advanced");
  write_gate_a: assert property (
    wr_q.vld |-> $past(ack_q) && $past(i2c_q) == tsc_pkg::TSC_I_WDATA &&
    !$past(stop_w))
    else $error("write without data ack");
  burst_len_a: assert property (
    @(posedge mod_clk_i) disable iff (!rst_n_i)
    (mtgl_q[2] ^ mtgl_q[1]) && !xfer_q.cal
    |=> burst_q == 20'(tsc_pkg::INTEG_PULSES) << xfer_q.exp)
    else $error("burst length wrong");

  free_cov_c: cover property (
    start_s && cal_s && sched_q == tsc_pkg::TSC_S_RUN);
  shot_cov_c: cover property (start_s && sched_q == tsc_pkg::TSC_S_SHOT);
  write_cov_c: cover property (
    wr_q.vld && wr_q.addr == tsc_pkg::ADDR_ACQ_CTL);
  read_cov_c: cover property (
    ack_end_w && i2c_q == tsc_pkg::TSC_I_RDATA && mack_q);
endmodule

// file: dv/test_tof_sampling_control_regs.sv
module test_tof_sampling_control_regs;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int         UNIT     = 10;
  localparam logic [7:0] DEV_ID   = 8'h3C; // arbitrary value
  localparam logic [6:0] I2C_ADDR = 7'h57;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic mod_clk_i = 1'b0;
  logic chip_disable_pin_i = 1'b0;
  logic trigger_i = 1'b0;
  logic vdd_ok_i = 1'b1;
  logic scl, host_oe_n, dut_sda, dut_oe_n, sda_w;
  logic emitter_drive_o, sample_start_o, cal_sample_o;
  int failures = 0;
  int cmp_count = 0;
  int n_start = 0, n_cal = 0, iv = 0, iv_cyc = 0;
  int pul = 0, pul_iv = 0, lights = 0, cal_gap = 0;
  logic [7:0] cal_hist = 8'h00;
  logic seen_q = 1'b0;

  always #50 clk_i = ~clk_i;
  // odd phase keeps link edges clear of the sampling edges below
  initial begin
    #3;
    forever #6 mod_clk_i = ~mod_clk_i;
  end
  // open drain wire with pull-up
  assign sda_w = host_oe_n & (dut_oe_n | dut_sda);

  tsc_regs #(.UNIT_CYC(UNIT), .DEV_ID(DEV_ID), .I2C_ADDR(I2C_ADDR)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mod_clk_i(mod_clk_i),
    .scl_i(scl), .sda_i(sda_w), .sda_o(dut_sda), .sda_oe_n_o(dut_oe_n),
    .chip_disable_pin_i(chip_disable_pin_i), .trigger_i(trigger_i),
    .vdd_ok_i(vdd_ok_i), .emitter_drive_o(emitter_drive_o),
    .sample_start_o(sample_start_o), .cal_sample_o(cal_sample_o));
  tsc_i2c_host host_u (.clk_i(clk_i), .sda_i(sda_w), .scl_o(scl),
    .sda_oe_n_o(host_oe_n));

  always @(posedge emitter_drive_o) pul++;
  always @(negedge clk_i) begin
    iv_cyc++;
    if (seen_q) begin
      cal_hist = {cal_hist[6:0], cal_sample_o};
      if (cal_sample_o) begin
        n_cal++;
        cal_gap = lights;
        lights = 0;
      end else begin
        lights++;
      end
    end
    seen_q = sample_start_o;
    if (sample_start_o) begin
      n_start++;
      iv = iv_cyc;
      iv_cyc = 0;
      pul_iv = pul;
      pul = 0;
    end
  end

  task automatic check(input string nm, input logic [31:0] exp,
                       input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic results();
    if (failures == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic do_reset();
    rst_n_i = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 rst_n_i = 1'b1;
  endtask

  task automatic head(input logic [7:0] a);
    logic ack;
    host_u.start();
    host_u.send({I2C_ADDR, 1'b0}, 8, ack);
    check("id ack", 1, ack);
    host_u.send(a, 8, ack);
    check("addr ack", 1, ack);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input int nb = 8);
    logic ack;
    head(a);
    host_u.send(d, nb, ack);
    if (nb == 8) check("data ack", 1, ack);
    host_u.stop();
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e[$]);
    logic ack;
    logic [7:0] b;
    head(a);
    host_u.start();
    host_u.send({I2C_ADDR, 1'b1}, 8, ack);
    check("read id ack", 1, ack);
    foreach (e[i]) begin
      host_u.recv(i == e.size() - 1, b);
      check($sformatf("reg %0h", a + i), e[i], b);
    end
    host_u.stop();
  endtask

  // trigger, then count sample starts over a fixed window
  task automatic trig_cnt(input int n);
    int n0 = n_start;
    trigger_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1 trigger_i = 1'b0;
    repeat (100) @(posedge clk_i);
    #1;
    check("sample starts", n, n_start - n0);
  endtask

  task automatic shot(input logic [7:0] acq, input int n,
                      input logic [7:0] h);
    wr(8'h13, acq);
    trig_cnt(n);
    check("cal order", h, cal_hist & 8'((1 << n) - 1));
  endtask

  task automatic wait_starts(input int k);
    int n0 = n_start;
    for (int i = 0; i < 9000 && n_start < n0 + k; i++) @(posedge clk_i);
    #1;
    check("starts seen", 1, n_start >= n0 + k);
  endtask

  task automatic wait_cal(input int k);
    int n0 = n_cal;
    for (int i = 0; i < 9000 && n_cal < n0 + k; i++) @(posedge clk_i);
    #1;
    check("cals seen", 1, n_cal >= n0 + k);
  endtask

  initial begin
    logic ack;
    do_reset();
    rd(8'h10, {8'h02, 8'h00, 8'h00, 8'h7C});
    rd(8'h00, {DEV_ID, 8'h00, 8'h07});
    vdd_ok_i = 1'b0;
    rd(8'h02, {8'h03});
    vdd_ok_i = 1'b1;
    chip_disable_pin_i = 1'b1;
    rd(8'h02, {8'h06});
    trig_cnt(0);
    chip_disable_pin_i = 1'b0;
    wr(8'h01, 8'h01);
    rd(8'h01, {8'h01, 8'h06});
    trig_cnt(0);
    wr(8'h01, 8'h00);
    wr(8'h00, 8'hFF);
    wr(8'h02, 8'hFF);
    rd(8'h00, {DEV_ID, 8'h00, 8'h07});
    wr(8'h11, 8'h55, 4);
    rd(8'h11, {8'h00});
    rd(8'h20, {8'h00});
    host_u.start();
    host_u.send({7'h12, 1'b0}, 8, ack);
    check("foreign id ack", 0, ack);
    host_u.stop();
    shot(8'h11, 2, 8'h02);
    shot(8'h13, 2, 8'h01);
    shot(8'h01, 1, 8'h00);
    wr(8'h10, 8'h00);
    wr(8'h11, 8'h02);
    wr(8'h13, 8'h00);
    trig_cnt(4);
    for (int s = 0; s < 4; s++) begin
      wr(8'h12, 8'(s));
      wait_starts(3);
      check("interval", UNIT * 3 << s, iv);
    end
    for (int g = 0; g < 3; g++) begin
      wr(8'h10, 8'(g));
      wait_starts(3);
      check("pulses", 320 << g, pul_iv);
    end
    wr(8'h11, 8'h00);
    wr(8'h12, 8'h00);
    wait_starts(3);
    check("interval", UNIT, iv);
    for (int c = 0; c < 4; c++) begin
      wr(8'h13, 8'h10 | 8'(c << 2));
      wait_cal(2);
      check("cal gap", 16 << c, cal_gap);
    end
    wr(8'h12, 8'h03);
    wr(8'h11, 8'h05);
    do_reset();
    rd(8'h10, {8'h02, 8'h00, 8'h00, 8'h7C});
    results();
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    check("watchdog", 0, 1);
    results();
  end
endmodule

// file: dv/tsc_i2c_host.sv
module tsc_i2c_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    scl_o = 1'b1;
    sda_oe_n_o = 1'b1;
  end

  // six clocks a phase keeps scl well above the four clock minimum
  task automatic hold(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic start();
    sda_oe_n_o = 1'b1;
    hold(4);
    scl_o = 1'b1;
    hold(6);
    sda_oe_n_o = 1'b0;
    hold(6);
    scl_o = 1'b0;
    hold(2);
  endtask

  task automatic stop();
    sda_oe_n_o = 1'b0;
    hold(4);
    scl_o = 1'b1;
    hold(6);
    sda_oe_n_o = 1'b1;
    hold(6);
  endtask

  // wire level taken mid high phase, after the device output has settled
  task automatic clock_bit(input logic b, output logic s);
    sda_oe_n_o = b;
    hold(6);
    scl_o = 1'b1;
    hold(3);
    s = sda_i;
    hold(3);
    scl_o = 1'b0;
    hold(2);
  endtask

  // fewer than eight bits leaves the byte and its ack unfinished
  task automatic send(input logic [7:0] b, input int nbits,
                      output logic ack);
    logic s;
    ack = 1'b0;
    for (int i = 7; i > 7 - nbits; i--) clock_bit(b[i], s);
    if (nbits == 8) begin
      clock_bit(1'b1, s);
      ack = ~s;
    end
  endtask

  // ack keeps the read going, nack on the last byte ends it
  task automatic recv(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) clock_bit(1'b1, b[i]);
    clock_bit(last, s);
  endtask
endmodule

// file: shared/tsc_pkg.sv
// Functional notes
// - master control bit 0 disables like the chip-disable pin; 0 enables.
// - status bit 0 output enabled, bit 1 ready, bit 2 power-good.
// - integration is 71.1 us times two to the field; exponent capped at 11.
// - integration setting fixes modulation cycles on the emitter drive pin.
// - sample start spacing is 450 us times sample period field plus one.
// - scaling field multiplies the sample period by 1, 2, 4 or 8.
// - mode bit 0 clear: free running after one trigger, repeating each period.
// - mode bit 0 set: one sample set per external trigger, idle between.
// - single shot: order bit 0 puts calibration first, 1 puts it last.
// - free running: calibration after every 16, 32, 64 or 128 light samples.
// - multi-byte read advances the address after each acknowledged byte.
// - a write commits only after a full data byte and its acknowledge.
package tsc_pkg;
  localparam logic [7:0] ADDR_DEV_ID   = 8'h00;
  localparam logic [7:0] ADDR_MSTR_CTL = 8'h01;
  localparam logic [7:0] ADDR_STATUS   = 8'h02;
  localparam logic [7:0] ADDR_INTEG    = 8'h10;
  localparam logic [7:0] ADDR_PERIOD   = 8'h11;
  localparam logic [7:0] ADDR_SCALE    = 8'h12;
  localparam logic [7:0] ADDR_ACQ_CTL  = 8'h13;

  localparam logic       RST_MSTR_CTL  = 1'h0;
  localparam logic [3:0] RST_INTEG     = 4'h2;
  localparam logic [7:0] RST_PERIOD    = 8'h00;
  localparam logic [1:0] RST_SCALE     = 2'h0;
  localparam logic [7:0] RST_ACQ_CTL   = 8'h7C;

  localparam int ACQ_MODE_BIT  = 0;
  localparam int CAL_ORDER_BIT = 1;
  localparam int CAL_RATE_LSB  = 2;
  localparam int LIGHT_EN_BIT  = 4;
  localparam int STAT_ENOUT    = 0;
  localparam int STAT_READY    = 1;
  localparam int STAT_VDD_OK   = 2;

  localparam int CLK_KHZ        = 10000;
  localparam int MOD_KHZ        = 4500;
  localparam int PERIOD_BASE_US = 450;
  localparam int INTEG_BASE_NS  = 71100;
  localparam int PERIOD_UNIT_CYC = PERIOD_BASE_US * CLK_KHZ / 1000;
  // least time, rounded up to whole modulation cycles
  localparam int INTEG_PULSES =
    (INTEG_BASE_NS * MOD_KHZ + 999999) / 1000000;
  localparam logic [3:0] INTEG_MAX_EXP = 4'hB;
  localparam logic [7:0] CAL_BASE_CNT  = 8'h10;

  typedef enum logic [2:0] {
    TSC_I_IDLE  = 3'b000,
    TSC_I_DEVID = 3'b001,
    TSC_I_REGAD = 3'b011,
    TSC_I_WDATA = 3'b010,
    TSC_I_RDATA = 3'b110
  } tsc_i2c_e;

  typedef enum logic [1:0] {
    TSC_S_IDLE = 2'b00,
    TSC_S_RUN  = 2'b01,
    TSC_S_SHOT = 2'b11
  } tsc_sched_e;

  typedef struct packed {
    logic       vld;
    logic [7:0] addr;
    logic [7:0] data;
  } tsc_wr_s;

  typedef struct packed {
    logic       cal;
    logic [3:0] exp;
  } tsc_xfer_s;
endpackage
